// ### design/umcr_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - a clear clock-select bit passes every input clock to the baud logic, a set one every fourth.
// - threshold-access set maps the threshold and trigger-level registers in; clear does not.
// - bit 5 turns the resume-on-any-character function on when set and off when clear.
// - loop-back routes transmit to receive and the low four control bits to upper status.
// - in loop-back control bits 3,2,1,0 show as status bits 7,6,4,5.
// - interrupt-output-enable clear floats both interrupt outputs and drives general output high.
// - interrupt-output-enable set drives both interrupt outputs and general output low.
// - bit 2 enables the FIFO-ready status register when set and disables it when clear.
// - bit 1 set drives the active-low request-to-send low, clear drives it high.
// - with automatic request-to-send on, the flow-control logic drives request-to-send instead.
// - bit 0 set drives the active-low data-terminal-ready low, clear drives it high.
// - writes to the top three control bits are dropped unless the enhanced write enable is set.
// - each upper status bit is its modem input inverted, or in loop-back the control bit.
module umcr_top
  import umcr_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [DATA_W-1:0] readdata,
  output logic                   waitrequest,
  // modem pins
  input  wire umcr_modem_in_t    modem_in,
  output logic                   rts_n,
  output logic                   dtr_n,
  // serial path
  input  wire logic              tx_from_transmitter,
  input  wire logic              rx_pin,
  output logic                   tx_pin,
  output logic                   rx_to_receiver,
  // interrupt pins
  input  wire logic              int_a_req,
  input  wire logic              int_b_req,
  output logic                   channel_a_interrupt_out,
  output logic                   channel_a_interrupt_oe,
  output logic                   channel_b_interrupt_out,
  output logic                   channel_b_interrupt_oe,
  output logic                   general_purpose_output,
  // flow control and baud logic
  input  wire logic              hw_rts_assert,
  input  wire logic              rx_char_valid,
  input  wire logic              rx_char_is_xon,
  input  wire logic              rx_char_is_xoff,
  output logic                   tx_halted,
  output logic                   baud_clk_en,
  output umcr_ctrl_t             ctrl,
  output logic      [3:0]        modem_status_upper
);

  function automatic logic [3:0] status_hi(input logic loop, input logic [7:0] ctl,
                                           input umcr_modem_in_t m);
    if (loop) begin
      status_hi = {ctl[3], ctl[2], ctl[0], ctl[1]};
    end else begin
      status_hi = ~{m.cd_n, m.ri_n, m.dsr_n, m.cts_n};
    end
  endfunction : status_hi

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state on every access
  logic [7:0]        mctl_q;
  logic [7:0]        enh_q;
  logic [7:0]        flow_q;
  logic              wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rd_word;
  logic              acc_wr;
  logic              wr_low;

  assign acc_wr = write && !wait_q;
  // only the low lane carries data; a write without it is ignored
  assign wr_low = acc_wr && byteenable[0];

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((read || write) && wait_q);
    end
  end

  always_comb begin
    rd_word = '0;
    unique case (address)
      OFS_MODEM_CONTROL: rd_word[7:0] = mctl_q;
      OFS_ENH_FEATURE:   rd_word[7:0] = enh_q;
      OFS_MODEM_STATUS:  rd_word[7:4] = status_hi(mctl_q[MC_LOOP], mctl_q, modem_in);
      OFS_FLOW_CONTROL:  rd_word[7:0] = flow_q;
      default:           rd_word = '0;
    endcase
  end

  // read data is caught while waitrequest is still high and held through the accept edge
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= '0;
    end else if (read && wait_q) begin
      rdata_q <= rd_word;
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mctl_q <= MC_RST;
    end else if (wr_low && address == OFS_MODEM_CONTROL) begin
      if (enh_q[ENH_WEN]) begin
        mctl_q <= writedata[7:0];
      end else begin
        mctl_q <= (writedata[7:0] & ~MC_PROT_MASK) | (mctl_q & MC_PROT_MASK);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      enh_q <= ENH_RST;
    end else if (wr_low && address == OFS_ENH_FEATURE) begin
      enh_q <= writedata[7:0];
    end
  end

  // only the automatic request-to-send bit is kept; the rest read as zero
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flow_q <= FLOW_RST;
    end else if (wr_low && address == OFS_FLOW_CONTROL) begin
      flow_q <= {7'h00, writedata[FLOW_AUTO_RTS]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modem and interrupt pins
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end else begin
      if (flow_q[FLOW_AUTO_RTS]) begin
        rts_n <= !hw_rts_assert;
      end else begin
        rts_n <= !mctl_q[MC_RTS];
      end
      dtr_n <= !mctl_q[MC_DTR];
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      channel_a_interrupt_out <= 1'b0;
      channel_b_interrupt_out <= 1'b0;
      channel_a_interrupt_oe  <= 1'b0;
      channel_b_interrupt_oe  <= 1'b0;
      general_purpose_output  <= 1'b1;
    end else begin
      channel_a_interrupt_out <= int_a_req;
      channel_b_interrupt_out <= int_b_req;
      channel_a_interrupt_oe  <= mctl_q[MC_IRQ_OE];
      channel_b_interrupt_oe  <= mctl_q[MC_IRQ_OE];
      general_purpose_output  <= !mctl_q[MC_IRQ_OE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loop-back and status
  // in loop-back the line is held idle so the far end sees no stray data
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_pin             <= 1'b1;
      rx_to_receiver     <= 1'b1;
      modem_status_upper <= 4'h0;
    end else begin
      tx_pin             <= mctl_q[MC_LOOP] ? 1'b1 : tx_from_transmitter;
      rx_to_receiver     <= mctl_q[MC_LOOP] ? tx_from_transmitter : rx_pin;
      modem_status_upper <= status_hi(mctl_q[MC_LOOP], mctl_q, modem_in);
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl <= '0;
    end else begin
      ctrl.threshold_access  <= mctl_q[MC_THR_ACC];
      ctrl.xon_any_enable    <= mctl_q[MC_XON_ANY];
      ctrl.fifo_ready_enable <= mctl_q[MC_FIFO_RDY];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud prescaler
  logic [1:0] div_cnt_q;
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_cnt_q   <= 2'h0;
      baud_clk_en <= 1'b0;
    end else begin
      div_cnt_q   <= div_cnt_q + 2'h1;
      baud_clk_en <= mctl_q[MC_CLK_SEL] ? (div_cnt_q == DIV4_LAST) : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit halt and resume
  umcr_tx_state_t tx_state_q;
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_state_q <= UMCR_TX_RUN;
    end else if (rx_char_valid) begin
      unique case (tx_state_q)
        UMCR_TX_RUN: begin
          if (rx_char_is_xoff) begin
            tx_state_q <= UMCR_TX_HALT;
          end
        end
        UMCR_TX_HALT: begin
          // an xoff never releases the halt, even with resume-on-any
          if (rx_char_is_xon || (mctl_q[MC_XON_ANY] && !rx_char_is_xoff)) begin
            tx_state_q <= UMCR_TX_RUN;
          end
        end
      endcase
    end
  end

  assign tx_halted = tx_state_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_q);
  // the select must have stood four cycles, else the last undivided pulse is still in view
  property p_div4;
    baud_clk_en && $past(mctl_q[MC_CLK_SEL], 1) && $past(mctl_q[MC_CLK_SEL], 2)
      && $past(mctl_q[MC_CLK_SEL], 3) && $past(mctl_q[MC_CLK_SEL], 4)
      |-> !$past(baud_clk_en, 1) && !$past(baud_clk_en, 2) && !$past(baud_clk_en, 3);
  endproperty
  a_div4: assert property (p_div4) else $error("prescaler pulse closer than four cycles");
  property p_div1;
    !mctl_q[MC_CLK_SEL] |=> baud_clk_en;
  endproperty
  a_div1: assert property (p_div1) else $error("undivided clock enable missing");
  property p_thr_acc;
    wr_low && address == OFS_MODEM_CONTROL && enh_q[ENH_WEN]
      |-> ##2 ctrl.threshold_access == $past(writedata[MC_THR_ACC], 2);
  endproperty
  a_thr_acc: assert property (p_thr_acc) else $error("threshold access not following write");
  property p_xon_any;
    ##1 ctrl.xon_any_enable == $past(mctl_q[MC_XON_ANY]);
  endproperty
  a_xon_any: assert property (p_xon_any) else $error("resume-on-any enable wrong");
  property p_loop_rx;
    mctl_q[MC_LOOP] |=> rx_to_receiver == $past(tx_from_transmitter) && tx_pin;
  endproperty
  a_loop_rx: assert property (p_loop_rx) else $error("loop-back serial path wrong");
  property p_loop_msr;
    mctl_q[MC_LOOP] |=> modem_status_upper
      == {$past(mctl_q[3]), $past(mctl_q[2]), $past(mctl_q[0]), $past(mctl_q[1])};
  endproperty
  a_loop_msr: assert property (p_loop_msr) else $error("loop-back status mapping wrong");
  property p_irq_off;
    !mctl_q[MC_IRQ_OE] |=> !channel_a_interrupt_oe && !channel_b_interrupt_oe
      && general_purpose_output;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt pins not floated");
  property p_irq_on;
    mctl_q[MC_IRQ_OE] |=> channel_a_interrupt_oe && channel_b_interrupt_oe
      && !general_purpose_output;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt pins not driven");
  property p_fifo_rdy;
    ##1 ctrl.fifo_ready_enable == $past(mctl_q[MC_FIFO_RDY]);
  endproperty
  a_fifo_rdy: assert property (p_fifo_rdy) else $error("fifo ready enable wrong");
  property p_rts_sw;
    !flow_q[FLOW_AUTO_RTS] |=> rts_n == !$past(mctl_q[MC_RTS]);
  endproperty
  a_rts_sw: assert property (p_rts_sw) else $error("request-to-send not from bit 1");
  property p_rts_auto;
    flow_q[FLOW_AUTO_RTS] |=> rts_n == !$past(hw_rts_assert);
  endproperty
  a_rts_auto: assert property (p_rts_auto) else $error("auto request-to-send wrong");
  property p_dtr;
    ##1 dtr_n == !$past(mctl_q[MC_DTR]);
  endproperty
  a_dtr: assert property (p_dtr) else $error("data-terminal-ready wrong");
  property p_protect;
    wr_low && address == OFS_MODEM_CONTROL && !enh_q[ENH_WEN]
      |=> mctl_q[7:5] == $past(mctl_q[7:5]) && mctl_q[4:0] == $past(writedata[4:0]);
  endproperty
  a_protect: assert property (p_protect) else $error("protected bits written");
  property p_msr_norm;
    !mctl_q[MC_LOOP] |=> modem_status_upper == ~$past(modem_in);
  endproperty
  a_msr_norm: assert property (p_msr_norm) else $error("status not inverse of pins");
  property p_resume;
    tx_halted && rx_char_valid && mctl_q[MC_XON_ANY] && !rx_char_is_xoff |=> !tx_halted;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume on any character");
  property p_readback;
    read && !waitrequest && address == OFS_MODEM_CONTROL |-> readdata[7:0] == mctl_q;
  endproperty
  a_readback: assert property (p_readback) else $error("control read-back mismatch");

  c_loop:    cover property (mctl_q[MC_LOOP] ##1 rx_to_receiver == tx_from_transmitter);
  c_div4:    cover property (mctl_q[MC_CLK_SEL] && baud_clk_en ##4 baud_clk_en);
  c_resume:  cover property (tx_halted && rx_char_valid && !rx_char_is_xon ##1 !tx_halted);
  c_protect: cover property (wr_low && address == OFS_MODEM_CONTROL && !enh_q[ENH_WEN]);

endmodule : umcr_top

// ### shared/umcr_pkg.sv
package umcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry and register byte offsets
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_MODEM_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_ENH_FEATURE   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MODEM_STATUS  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_FLOW_CONTROL  = 4'hC;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned MC_CLK_SEL    = 7;
  localparam int unsigned MC_THR_ACC    = 6;
  localparam int unsigned MC_XON_ANY    = 5;
  localparam int unsigned MC_LOOP       = 4;
  localparam int unsigned MC_IRQ_OE     = 3;
  localparam int unsigned MC_FIFO_RDY   = 2;
  localparam int unsigned MC_RTS        = 1;
  localparam int unsigned MC_DTR        = 0;
  localparam int unsigned ENH_WEN       = 4;
  localparam int unsigned FLOW_AUTO_RTS = 0;

  localparam logic [7:0] MC_PROT_MASK = 8'hE0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and counts
  localparam logic [7:0] MC_RST   = 8'h00;
  localparam logic [7:0] ENH_RST  = 8'h00;
  localparam logic [7:0] FLOW_RST = 8'h00;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } umcr_modem_in_t;

  typedef struct packed {
    logic threshold_access;
    logic xon_any_enable;
    logic fifo_ready_enable;
  } umcr_ctrl_t;

  typedef enum logic [0:0] {
    UMCR_TX_RUN  = 1'b0,
    UMCR_TX_HALT = 1'b1
  } umcr_tx_state_t;

endpackage : umcr_pkg

// ### tb/umcr_modem_model.sv
`timescale 1ns/10ps
module umcr_modem_model
  import umcr_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // lines the bench wants asserted, {cd,ri,dsr,cts}
  input  wire logic [3:0] assert_lines,
  // line side
  input  wire logic       tx_line,
  output umcr_modem_in_t  modem_in,
  output logic            rx_line
);
  // modem pins are active low
  assign modem_in = umcr_modem_in_t'(~assert_lines);

  initial rx_line = 1'b1;

  // loop cable: what the channel sends comes back one cycle later
  always @(posedge mclk) begin
    rx_line <= tx_line;
  end
endmodule : umcr_modem_model

// ### tb/umcr_top_tb.sv
`timescale 1ns/10ps
`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", name, exp, got); end end

module umcr_top_tb;
  import umcr_pkg::*;
  logic              mclk, reset_n, read, write, waitrequest;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writedata, readdata;
  logic [3:0]        byteenable, lines, status_upper;
  logic              rts_n, dtr_n, tx_from, rx_pin, tx_pin, rx_to_rcv, gpo;
  logic              int_a_req, int_b_req, int_a, int_a_oe, int_b, int_b_oe;
  logic              hw_rts, rx_valid, rx_xon, rx_xoff, tx_halted, baud_en;
  umcr_modem_in_t    modem_in;
  umcr_ctrl_t        ctrl;
  int                n_errors, check_count, seed, n;
  logic [7:0]        m, rd;
  logic [7:0]        corner [4] = '{8'h00, 8'hFF, 8'h15, 8'h9A};

  always #5 mclk = ~mclk;

  umcr_top u_umcr_top (
    .mclk(mclk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .modem_in(modem_in), .rts_n(rts_n), .dtr_n(dtr_n),
    .tx_from_transmitter(tx_from), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .rx_to_receiver(rx_to_rcv), .int_a_req(int_a_req), .int_b_req(int_b_req),
    .channel_a_interrupt_out(int_a), .channel_a_interrupt_oe(int_a_oe),
    .channel_b_interrupt_out(int_b), .channel_b_interrupt_oe(int_b_oe),
    .general_purpose_output(gpo), .hw_rts_assert(hw_rts), .rx_char_valid(rx_valid),
    .rx_char_is_xon(rx_xon), .rx_char_is_xoff(rx_xoff), .tx_halted(tx_halted),
    .baud_clk_en(baud_en), .ctrl(ctrl), .modem_status_upper(status_upper));

  umcr_modem_model u_umcr_modem_model (
    .mclk(mclk), .assert_lines(lines), .tx_line(tx_pin), .modem_in(modem_in),
    .rx_line(rx_pin));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] exp_status(input logic [7:0] c, input logic [3:0] l);
    return c[MC_LOOP] ? {c[3], c[2], c[0], c[1]} : l;
  endfunction : exp_status

  // one avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] q);
    @(posedge mclk);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF, rd);
  endtask : wreg

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF, rd);
    `CHK("readback", e, rd)
  endtask : rchk

  task automatic rx_char(input logic xon, input logic xoff, input logic e);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_xon <= xon;
    rx_xoff <= xoff;
    @(posedge mclk);
    rx_valid <= 1'b0;
    @(posedge mclk);
    `CHK("tx_halted", e, tx_halted)
  endtask : rx_char

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 0; reset_n = 0; read = 0; write = 0; address = '0; writedata = '0;
    byteenable = '0; lines = '0; tx_from = 1; int_a_req = 0; int_b_req = 0; hw_rts = 0;
    rx_valid = 0; rx_xon = 0; rx_xoff = 0; n_errors = 0; check_count = 0; seed = 32'h7e87;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK("rts_n", 1'b1, rts_n)
    `CHK("gpo", 1'b1, gpo)
    `CHK("int_a_oe", 1'b0, int_a_oe)
    rchk(OFS_MODEM_CONTROL, MC_RST);
    rchk(OFS_ENH_FEATURE, ENH_RST);
    rchk(OFS_FLOW_CONTROL, FLOW_RST);
    wreg(OFS_MODEM_CONTROL, 8'hFF);
    rchk(OFS_MODEM_CONTROL, 8'hFF & ~MC_PROT_MASK);
    bus(1'b1, OFS_MODEM_CONTROL, 8'h00, 4'h0, rd);
    rchk(OFS_MODEM_CONTROL, 8'h1F);
    wreg(4'h2, 8'hFF);
    rchk(4'h2, 8'h00);
    wreg(OFS_ENH_FEATURE, 8'h10);
    rchk(OFS_ENH_FEATURE, 8'h10);
    // corner values first, then random control bytes with random pin levels
    for (int k = 0; k < 16; k++) begin
      m = (k < 4) ? corner[k] : 8'($random(seed));
      {lines, int_a_req, int_b_req, tx_from} <= 7'($random(seed));
      wreg(OFS_MODEM_CONTROL, m);
      repeat (3) @(posedge mclk);
      n = 0;
      repeat (8) begin
        @(posedge mclk);
        n += int'(baud_en);
      end
      `CHK("baud pulses", (m[7] ? 2 : 8), n)
      `CHK("rts_n", ~m[1], rts_n)
      `CHK("dtr_n", ~m[0], dtr_n)
      `CHK("gpo", ~m[3], gpo)
      `CHK("int_a_oe", m[3], int_a_oe)
      `CHK("int_b_oe", m[3], int_b_oe)
      `CHK("int_a", int_a_req, int_a)
      `CHK("int_b", int_b_req, int_b)
      `CHK("ctrl", {m[6], m[5], m[2]}, ctrl)
      `CHK("status", exp_status(m, lines), status_upper)
      `CHK("tx_pin", (m[4] ? 1'b1 : tx_from), tx_pin)
      `CHK("rx_to_rcv", (m[4] ? tx_from : rx_pin), rx_to_rcv)
      rchk(OFS_MODEM_CONTROL, m);
      rchk(OFS_MODEM_STATUS, {exp_status(m, lines), 4'h0});
    end
    // automatic request-to-send overrides bit 1
    wreg(OFS_FLOW_CONTROL, 8'h01);
    for (int v = 0; v < 2; v++) begin
      hw_rts <= v[0];
      repeat (3) @(posedge mclk);
      `CHK("auto rts_n", ~v[0], rts_n)
    end
    wreg(OFS_FLOW_CONTROL, 8'h00);
    wreg(OFS_MODEM_CONTROL, 8'h00);
    rx_char(1'b0, 1'b1, 1'b1);
    rx_char(1'b0, 1'b0, 1'b1);
    rx_char(1'b1, 1'b0, 1'b0);
    wreg(OFS_MODEM_CONTROL, 8'h20);
    rx_char(1'b0, 1'b1, 1'b1);
    rx_char(1'b0, 1'b0, 1'b0);
    // protection back on: upper bits keep their value
    wreg(OFS_ENH_FEATURE, 8'h00);
    wreg(OFS_MODEM_CONTROL, 8'h00);
    rchk(OFS_MODEM_CONTROL, 8'h20);
    stop_test();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    stop_test();
  end
endmodule : umcr_top_tb
